// file: inc/nppf_cfg.svh
// Constants for the parameter page link: offsets, field positions, reset values and timing
// Operation
// - Byte 208 valid blocks, 209-210 endurance
// - Mandatory ECC record at bytes 211-218
// - Up to three optional ECC records follow
// - Reserved bytes and feature bits 9-15 zero
// - Vendor revision 420-421, vendor area 422-509
// - Integrity CRC in bytes 510-511
// - Page repeated at 512 and 1024 onward
// - Signature bytes 0-3; two matches mean valid
// - Revision bit 0 zero, 1 vendor, 2 rev1
// - Host uses width from feature bit 0
// - Bit 1 clear: issue only when all idle
// - Bit 2 clear: program pages in ascending order
// - Bits 3 and 4 advertise multi-plane support
// - Bit 5 only with synchronous DDR modes filled
// - Bit 6 only with strobe DDR modes filled
// - Bit 7 marks external programming supply
// - Bit 8 selects clearing addressed or all units
// - All page registers cleared at power-up
`ifndef NPPF_CFG_SVH
`define NPPF_CFG_SVH

// Page geometry
`define NPPF_PAGE_BYTES      11'd512
`define NPPF_OFS_SIG_LAST    9'd3
`define NPPF_OFS_REV_LO      9'd4
`define NPPF_OFS_REV_HI      9'd5
`define NPPF_OFS_FEAT_LO     9'd6
`define NPPF_OFS_FEAT_HI     9'd7
`define NPPF_OFS_SDDR_MODES  9'd141
`define NPPF_OFS_ADDR_MODES  9'd142
`define NPPF_OFS_VALID_BLK   9'd208
`define NPPF_OFS_VALID_END   9'd209
`define NPPF_OFS_ECC0        9'd211
`define NPPF_OFS_ECC_LAST    9'd242
`define NPPF_OFS_VREV        9'd420
`define NPPF_OFS_CRC_LO      9'd510
`define NPPF_OFS_CRC_HI      9'd511

// Feature word bit positions
`define NPPF_FB_WIDE         0
`define NPPF_FB_MULTI_UNIT   1
`define NPPF_FB_NONSEQ       2
`define NPPF_FB_MP_PROG      3
`define NPPF_FB_MP_READ      4
`define NPPF_FB_SDDR         5
`define NPPF_FB_ADDR         6
`define NPPF_FB_VPP          7
`define NPPF_FB_UNIT_CLR     8

// Integrity check
`define NPPF_CRC_INIT        16'hffff
`define NPPF_CRC_POLY        16'h8005

// Program busy time
`define NPPF_CLK_NS          100
`define NPPF_PROG_TIME_NS    2000

// Host register offsets and bits
`define NPPF_REG_CTRL        8'h00
`define NPPF_REG_PROG        8'h04
`define NPPF_REG_STATUS      8'h08
`define NPPF_REG_FEAT        8'h0c
`define NPPF_REG_REV         8'h10
`define NPPF_REG_READY       8'h14
`define NPPF_CTRL_LOAD       0
`define NPPF_CTRL_PROG       1
`define NPPF_ST_BUSY         0
`define NPPF_ST_VALID        1
`define NPPF_ST_FAIL         2
`define NPPF_ST_ORDER_ERR    3
`define NPPF_ST_REFUSED      4
`define NPPF_ST_WIDE         8

`endif

// file: inc/nppf_pkg.sv
// Types and the shared integrity check step for the parameter page link
`include "nppf_cfg.svh"
package nppf_pkg;
  // Host sequencer states
  typedef enum logic [2:0] {
    NPPF_IDLE,
    NPPF_RD_ISSUE,
    NPPF_RD_WAIT,
    NPPF_RD_CHECK,
    NPPF_PG_WAIT,
    NPPF_PG_BUSY
  } nppf_state_t;

  // One byte through the 16-bit check, MSB first
  function automatic logic [15:0] nppf_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int b = 7; b >= 0; b--) begin
      if (c[15] ^ data[b]) begin
        c = {c[14:0], 1'b0} ^ `NPPF_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage

// file: inc/nppf_if.sv
// Link between the page host and the flash target
`timescale 1ns/100ps
`default_nettype none
interface nppf_if #(parameter int NUNITS = 4);
  logic              rd_req;
  logic [10:0]       rd_addr;
  logic              rd_valid;
  logic [7:0]        rd_data;
  logic              prog_req;
  logic [1:0]        prog_unit;
  logic [NUNITS-1:0] rdy;
  logic [NUNITS-1:0] pgreg_full;
  logic              dev_ready;

  modport device (input rd_req, rd_addr, prog_req, prog_unit,
                  output rd_valid, rd_data, rdy, pgreg_full, dev_ready);
  modport host   (output rd_req, rd_addr, prog_req, prog_unit,
                  input rd_valid, rd_data, rdy, pgreg_full, dev_ready);
endinterface
`default_nettype wire

// file: design/nppf_pagereg.sv
// One logical unit: page register occupancy and ready/busy timer
`timescale 1ns/100ps
`default_nettype none
module nppf_pagereg
  import nppf_pkg::*;
#(
  parameter int BUSY_CYC = 20
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_clear,
  input  wire logic i_start,
  // State
  output logic      o_full,
  output logic      o_rdy
);
  logic [15:0] busy_cnt;

  // Occupancy: empty from power-up, cleared on request, filled by program start
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_full <= 1'b0;
    end else if (i_start) begin
      o_full <= 1'b1;
    end else if (i_clear) begin
      o_full <= 1'b0;
    end
  end

  // Busy timer holds ready low for the program time
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= 16'h0000;
      o_rdy    <= 1'b1;
    end else if (i_start) begin
      busy_cnt <= 16'(BUSY_CYC - 1);
      o_rdy    <= 1'b0;
    end else if (busy_cnt != 16'h0000) begin
      busy_cnt <= busy_cnt - 16'h0001;
    end else begin
      o_rdy    <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: design/nppf_device.sv
// Flash target end: parameter page content, copies, integrity check and page registers
`timescale 1ns/100ps
`default_nettype none
`include "nppf_cfg.svh"
module nppf_device
  import nppf_pkg::*;
#(
  parameter int          NUNITS       = 4,
  parameter int          NCOPIES      = 3,
  parameter logic [31:0] SIG_WORD     = 32'h5d5c5b5a, // Arbitrary signature value
  parameter logic        VENDOR_PAGE  = 1'b0,
  parameter logic        WIDE         = 1'b0,
  parameter logic        MULTI_UNIT   = 1'b0,
  parameter logic        NONSEQ       = 1'b0,
  parameter logic        MP_PROG      = 1'b1,
  parameter logic        MP_READ      = 1'b1,
  parameter logic [7:0]  SDDR_MODES   = 8'h00,
  parameter logic [7:0]  ADDR_MODES   = 8'h00,
  parameter logic        EXT_VPP      = 1'b0,
  parameter logic        UNIT_CLR     = 1'b1,
  parameter logic [7:0]  VALID_BLOCKS = 8'h01,
  parameter logic [15:0] VALID_ENDUR  = 16'h0003,
  parameter int          EXTRA_ECC    = 0,
  parameter logic [7:0]  ECC_BITS     = 8'h08,
  parameter logic [7:0]  ECC_CW       = 8'h09,
  parameter logic [15:0] BAD_MAX      = 16'h0014,
  parameter logic [15:0] ECC_ENDUR    = 16'h0003,
  parameter logic [15:0] VENDOR_REV   = 16'h0001
) (
  // Clock and reset
  input  wire logic  i_mclk,
  input  wire logic  i_rst_n,
  // Link
  nppf_if.device     link,
  // Observation
  output logic [15:0] o_page_crc,
  output logic        o_ready
);
  localparam int PROG_CYC = (`NPPF_PROG_TIME_NS + `NPPF_CLK_NS - 1) / `NPPF_CLK_NS;

  logic [15:0]       feat_word;
  logic [15:0]       rev_word;
  logic [8:0]        walk;
  logic [15:0]       crc;
  logic [NUNITS-1:0] clr_mask;
  logic [NUNITS-1:0] start_mask;
  logic [NUNITS-1:0] full_v;
  logic [NUNITS-1:0] rdy_v;
  logic [7:0]        rd_byte;

  // Feature and revision words; data interface bits follow their mode fields
  assign feat_word = {7'h00,
                      UNIT_CLR,
                      EXT_VPP,
                      ADDR_MODES != 8'h00,
                      SDDR_MODES != 8'h00,
                      MP_READ, MP_PROG,
                      NONSEQ, MULTI_UNIT, WIDE};
  assign rev_word  = {13'h0000, 1'b1, VENDOR_PAGE, 1'b0};

  // Content of one page offset, check bytes excluded
  function automatic logic [7:0] page_byte(input logic [8:0] off);
    logic [8:0] rel;
    logic [7:0] b;
    rel = off - `NPPF_OFS_ECC0;
    b   = 8'h00;
    if (off <= `NPPF_OFS_SIG_LAST) begin
      b = SIG_WORD[8*off[1:0] +: 8];
    end else if (off == `NPPF_OFS_REV_LO) begin
      b = rev_word[7:0];
    end else if (off == `NPPF_OFS_REV_HI) begin
      b = rev_word[15:8];
    end else if (off == `NPPF_OFS_FEAT_LO) begin
      b = feat_word[7:0];
    end else if (off == `NPPF_OFS_FEAT_HI) begin
      b = feat_word[15:8];
    end else if (off == `NPPF_OFS_SDDR_MODES) begin
      b = SDDR_MODES;
    end else if (off == `NPPF_OFS_ADDR_MODES) begin
      b = ADDR_MODES;
    end else if (off == `NPPF_OFS_VALID_BLK) begin
      b = VALID_BLOCKS;
    end else if (off == `NPPF_OFS_VALID_END) begin
      b = VALID_ENDUR[7:0];
    end else if (off == `NPPF_OFS_VALID_END + 9'd1) begin
      b = VALID_ENDUR[15:8];
    end else if (off >= `NPPF_OFS_ECC0 && off <= `NPPF_OFS_ECC_LAST) begin
      if (int'(rel[8:3]) <= EXTRA_ECC) begin
        case (rel[2:0])
          3'd0: b = ECC_BITS;
          3'd1: b = ECC_CW;
          3'd2: b = BAD_MAX[7:0];
          3'd3: b = BAD_MAX[15:8];
          3'd4: b = ECC_ENDUR[7:0];
          3'd5: b = ECC_ENDUR[15:8];
          default: b = 8'h00;
        endcase
      end
    end else if (off == `NPPF_OFS_VREV) begin
      b = VENDOR_REV[7:0];
    end else if (off == `NPPF_OFS_VREV + 9'd1) begin
      b = VENDOR_REV[15:8];
    end
    return b;
  endfunction

  // Integrity check walked over bytes 0-509 after reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      walk    <= 9'h000;
      crc     <= `NPPF_CRC_INIT;
      o_ready <= 1'b0;
    end else if (walk != `NPPF_OFS_CRC_LO) begin
      walk    <= walk + 9'h001;
      crc     <= nppf_crc_byte(crc, page_byte(walk));
    end else begin
      o_ready <= 1'b1;
    end
  end

  assign o_page_crc     = crc;
  assign link.dev_ready = o_ready;

  // Byte of any copy; copies beyond the last read zero
  always_comb begin
    rd_byte = 8'h00;
    if (int'(link.rd_addr[10:9]) < NCOPIES) begin
      if (link.rd_addr[8:0] == `NPPF_OFS_CRC_LO) begin
        rd_byte = crc[7:0];
      end else if (link.rd_addr[8:0] == `NPPF_OFS_CRC_HI) begin
        rd_byte = crc[15:8];
      end else begin
        rd_byte = page_byte(link.rd_addr[8:0]);
      end
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.rd_valid <= 1'b0;
      link.rd_data  <= 8'h00;
    end else begin
      link.rd_valid <= link.rd_req;
      link.rd_data  <= link.rd_req ? rd_byte : 8'h00;
    end
  end

  // Program clears one unit or every unit, then fills the addressed one
  always_comb begin
    clr_mask   = '0;
    start_mask = '0;
    if (link.prog_req) begin
      start_mask[link.prog_unit] = 1'b1;
      clr_mask = UNIT_CLR ? start_mask : '1;
    end
  end

  // One page register and busy timer per logical unit
  genvar u;
  generate
    for (u = 0; u < NUNITS; u++) begin : g_unit
      nppf_pagereg #(.BUSY_CYC(PROG_CYC)) u_reg (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_clear (clr_mask[u]),
        .i_start (start_mask[u]),
        .o_full  (full_v[u]),
        .o_rdy   (rdy_v[u])
      );
    end
  endgenerate

  assign link.pgreg_full = full_v;
  assign link.rdy        = rdy_v;
endmodule
`default_nettype wire

// file: design/nppf_host.sv
// Host end: loads and checks the parameter page, then issues programs under its limits
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "nppf_cfg.svh"
module nppf_host
  import nppf_pkg::*;
#(
  parameter int NUNITS  = 4,
  parameter int NCOPIES = 3
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Link
  nppf_if.host             link
);
  nppf_state_t state;
  logic [8:0]  off;
  logic [1:0]  copy;
  logic [15:0] crc;
  logic [15:0] got_crc;
  logic [2:0]  sig_hits;
  logic [15:0] feat;
  logic [15:0] rev;
  logic        valid;
  logic        fail;
  logic        order_err;
  logic        refused;
  logic [1:0]  unit;
  logic [7:0]  page;
  logic [7:0]  next_page [NUNITS];
  logic        wr_ctrl;
  logic        req;
  logic        page_ok;
  logic        units_idle;

  assign req     = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_ctrl = req && i_wb_we && i_wb_sel[0] && i_wb_adr == `NPPF_REG_CTRL;

  // Page order check and concurrency gate from the feature word
  assign page_ok    = feat[`NPPF_FB_NONSEQ] || page == 8'h00 || page == next_page[unit];
  assign units_idle = feat[`NPPF_FB_MULTI_UNIT] ? link.rdy[unit] : &link.rdy;

  // Bus answer one cycle after the request, unmapped reads zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= 32'h0000_0000;
      if (req && !i_wb_we) begin
        if (i_wb_adr == `NPPF_REG_PROG) begin
          o_wb_dat <= {16'h0000, page, 6'h00, unit};
        end else if (i_wb_adr == `NPPF_REG_STATUS) begin
          o_wb_dat <= {23'h000000, feat[`NPPF_FB_WIDE], 1'b0, copy,
                       refused, order_err, fail, valid, state != NPPF_IDLE};
        end else if (i_wb_adr == `NPPF_REG_FEAT) begin
          o_wb_dat <= {16'h0000, feat};
        end else if (i_wb_adr == `NPPF_REG_REV) begin
          o_wb_dat <= {16'h0000, rev};
        end else if (i_wb_adr == `NPPF_REG_READY) begin
          o_wb_dat <= {23'h000000, link.dev_ready, 8'(link.rdy)};
        end
      end
    end
  end

  // Program target unit and page
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unit <= 2'd0;
      page <= 8'h00;
    end else if (req && i_wb_we && i_wb_adr == `NPPF_REG_PROG) begin
      if (i_wb_sel[0]) begin
        unit <= i_wb_dat[1:0];
      end
      if (i_wb_sel[1]) begin
        page <= i_wb_dat[15:8];
      end
    end
  end

  // Load and program sequencer
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state         <= NPPF_IDLE;
      off           <= 9'h000;
      copy          <= 2'd0;
      crc           <= `NPPF_CRC_INIT;
      got_crc       <= 16'h0000;
      sig_hits      <= 3'd0;
      feat          <= 16'h0000;
      rev           <= 16'h0000;
      valid         <= 1'b0;
      fail          <= 1'b0;
      link.rd_req   <= 1'b0;
      link.rd_addr  <= 11'h000;
      link.prog_req <= 1'b0;
      link.prog_unit <= 2'd0;
    end else begin
      link.rd_req   <= 1'b0;
      link.prog_req <= 1'b0;
      case (state)
        NPPF_IDLE: begin
          if (wr_ctrl && i_wb_dat[`NPPF_CTRL_LOAD] && link.dev_ready) begin
            valid    <= 1'b0;
            fail     <= 1'b0;
            copy     <= 2'd0;
            off      <= 9'h000;
            crc      <= `NPPF_CRC_INIT;
            sig_hits <= 3'd0;
            state    <= NPPF_RD_ISSUE;
          end else if (wr_ctrl && i_wb_dat[`NPPF_CTRL_PROG] && valid && page_ok) begin
            state <= NPPF_PG_WAIT;
          end
        end
        NPPF_RD_ISSUE: begin
          link.rd_req  <= 1'b1; // Identification bytes move 8 bits at a time
          link.rd_addr <= {copy, off};
          state        <= NPPF_RD_WAIT;
        end
        NPPF_RD_WAIT: begin
          if (link.rd_valid) begin
            if (off <= `NPPF_OFS_SIG_LAST && link.rd_data == SIG_BYTE(off[1:0])) begin
              sig_hits <= sig_hits + 3'd1;
            end
            if (off < `NPPF_OFS_CRC_LO) begin
              crc <= nppf_crc_byte(crc, link.rd_data);
            end
            if (off == `NPPF_OFS_REV_LO) rev[7:0] <= link.rd_data;
            if (off == `NPPF_OFS_REV_HI) rev[15:8] <= link.rd_data;
            if (off == `NPPF_OFS_FEAT_LO) feat[7:0] <= link.rd_data;
            if (off == `NPPF_OFS_FEAT_HI) feat[15:8] <= link.rd_data;
            if (off == `NPPF_OFS_CRC_LO) got_crc[7:0] <= link.rd_data;
            if (off == `NPPF_OFS_CRC_HI) got_crc[15:8] <= link.rd_data;
            off   <= off + 9'h001;
            state <= (off == `NPPF_OFS_CRC_HI) ? NPPF_RD_CHECK : NPPF_RD_ISSUE;
          end
        end
        NPPF_RD_CHECK: begin
          if (sig_hits >= 3'd2 && got_crc == crc) begin
            valid <= 1'b1;
            state <= NPPF_IDLE;
          end else if (int'(copy) + 1 < NCOPIES) begin
            copy     <= copy + 2'd1;
            off      <= 9'h000;
            crc      <= `NPPF_CRC_INIT;
            sig_hits <= 3'd0;
            state    <= NPPF_RD_ISSUE;
          end else begin
            fail  <= 1'b1;
            state <= NPPF_IDLE;
          end
        end
        NPPF_PG_WAIT: begin
          if (units_idle) begin
            link.prog_req  <= 1'b1;
            link.prog_unit <= unit;
            state          <= NPPF_PG_BUSY;
          end
        end
        NPPF_PG_BUSY: begin
          if (!link.rdy[unit]) begin
            state <= NPPF_IDLE;
          end
        end
        default: state <= NPPF_IDLE;
      endcase
    end
  end

  // Expected signature byte, same arbitrary value as the target default
  function automatic logic [7:0] SIG_BYTE(input logic [1:0] k);
    logic [31:0] w;
    w = 32'h5d5c5b5a;
    return w[8*k +: 8];
  endfunction

  // Refusal and order error flags; each program attempt made in idle sets them anew
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      order_err <= 1'b0;
      refused   <= 1'b0;
    end else if (state == NPPF_IDLE && wr_ctrl && i_wb_dat[`NPPF_CTRL_PROG]) begin
      order_err <= valid && !page_ok;
      refused   <= !valid || !page_ok;
    end
  end

  // Next expected page per unit; page 0 restarts a block
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NUNITS; i++) begin
        next_page[i] <= 8'h00;
      end
    end else if (state == NPPF_PG_WAIT && units_idle) begin
      next_page[unit] <= page + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: verif/nppf_sva.sv
// Checker of the link between the page host and the flash target
`timescale 1ns/100ps
`default_nettype none
module nppf_sva #(
  parameter int          NUNITS   = 4,
  parameter int          NCOPIES  = 3,
  parameter logic [31:0] SIG_WORD = 32'h5d5c5b5a // Arbitrary signature value
) (
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  // Link
  input  wire logic              rd_req,
  input  wire logic [10:0]       rd_addr,
  input  wire logic              rd_valid,
  input  wire logic [7:0]        rd_data,
  input  wire logic              prog_req,
  input  wire logic [1:0]        prog_unit,
  input  wire logic [NUNITS-1:0] rdy,
  input  wire logic [NUNITS-1:0] pgreg_full,
  input  wire logic              dev_ready
);
  logic [7:0] low_cnt;
  logic       prog_seen;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Counts cycles in which some unit is busy
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= (&rdy) ? 8'h00 : low_cnt + 8'h01;
    end
  end
  // Remembers that a program was sent
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prog_seen <= 1'b0;
    end else begin
      prog_seen <= prog_seen | prog_req;
    end
  end
  // Link read answers
  rd_answer_a: assert property (rd_req |=> rd_valid) else $error("read not answered");
  rd_pulse_a: assert property (rd_valid |=> !rd_valid) else $error("read valid too long");
  sig_byte_a: assert property (rd_req && rd_addr[8:0] == 9'd0 && rd_addr[10:9] < NCOPIES
    |=> rd_data == SIG_WORD[7:0]) else $error("signature byte wrong");
  rsvd_zero_a: assert property (rd_req && rd_addr[8:0] inside {[9'd243:9'd419]}
    |=> rd_data == 8'h00) else $error("reserved byte not zero");
  copy_zero_a: assert property (rd_req && rd_addr[10:9] >= NCOPIES |=> rd_data == 8'h00)
    else $error("absent copy not zero");
  // Programs and page registers
  prog_idle_a: assert property (prog_req |-> &rdy) else $error("program while a unit busy");
  prog_fill_a: assert property (prog_req |=> pgreg_full[$past(prog_unit)]
    && !rdy[$past(prog_unit)]) else $error("program not taken");
  keep_other_a: assert property (prog_req |=> (pgreg_full & ~(NUNITS'(1) << $past(prog_unit)))
    == ($past(pgreg_full) & ~(NUNITS'(1) << $past(prog_unit)))) else $error("other unit changed");
  pwr_clear_a: assert property (!prog_seen |-> pgreg_full == '0) else $error("page register not clear");
  busy_time_a: assert property ($rose(&rdy) |-> low_cnt == 8'd20) else $error("busy time wrong");
  // Main scenarios
  prog_c: cover property (prog_req);
  ready_c: cover property ($rose(dev_ready));
  crc_rd_c: cover property (rd_req && rd_addr[8:0] == 9'd511);
endmodule
`default_nettype wire

// file: verif/nppf_test.sv
// Self-checking bench joining the page host and the flash target
`timescale 1ns/100ps
`default_nettype none
`include "nppf_cfg.svh"
module nppf_test;
  logic        i_mclk  = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [15:0] page_crc;
  logic        dev_ok;
  logic [63:0] e;
  logic [10:0] la;
  logic [63:0] exp_q[$];
  logic [10:0] adr_q[$];
  logic [7:0]  pg[512];
  logic [31:0] rdat_b;
  logic [10:0] lb;
  logic [10:0] adr_qb[$];
  logic [7:0]  pgb[512];
  int          bad_count   = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  // Expected page bytes: {offset, value}
  localparam logic [16:0] TAB[21] = '{{9'd0, 8'h5a}, {9'd1, 8'h5b}, {9'd2, 8'h5c}, {9'd3, 8'h5d},
    {9'd4, 8'h04}, {9'd5, 8'h00}, {9'd6, 8'h18}, {9'd7, 8'h01}, {9'd208, 8'h01}, {9'd209, 8'h03},
    {9'd210, 8'h00}, {9'd211, 8'h08}, {9'd212, 8'h09}, {9'd213, 8'h14}, {9'd214, 8'h00},
    {9'd215, 8'h03}, {9'd216, 8'h00}, {9'd217, 8'h00}, {9'd218, 8'h00}, {9'd420, 8'h01}, {9'd421, 8'h00}};
  nppf_if #(.NUNITS(4)) link ();
  nppf_device i_nppf_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link),
    .o_page_crc(page_crc), .o_ready(dev_ok));
  nppf_host i_nppf_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .link(link));
  // Second pair: signature matches in one byte only, so the host reads and refuses every copy
  nppf_if #(.NUNITS(4)) link_b ();
  nppf_device #(.SIG_WORD(32'h5d000000)) i_nppf_device_b (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .link(link_b),
    .o_page_crc(), .o_ready());
  nppf_host i_nppf_host_b (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat_b),
    .o_wb_ack(), .link(link_b));
  nppf_sva i_nppf_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .rd_req(link.rd_req),
    .rd_addr(link.rd_addr), .rd_valid(link.rd_valid), .rd_data(link.rd_data),
    .prog_req(link.prog_req), .prog_unit(link.prog_unit), .rdy(link.rdy),
    .pgreg_full(link.pgreg_full), .dev_ready(link.dev_ready));
  // Clock of 100 ns
  always #50 i_mclk = ~i_mclk;
  // Prints counts and verdict, ends the run
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compares bus words
  task automatic cmp_word(input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR at %0t: expected %h got %h", $time, x, g);
    end
  endtask
  // Compares link bytes
  task automatic cmp_byte(input logic [7:0] x, input logic [7:0] g);
    cmp_word({24'h0, x}, {24'h0, g});
  endtask
  // One classic Wishbone cycle; a read notes its masked expectation
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    output logic [31:0] r);
    @(posedge i_mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    if (!w) exp_q.push_back({m, d});
    do @(posedge i_mclk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Program one unit and check the refusal flags
  task automatic prog(input logic [1:0] u, input logic [7:0] p, input logic [31:0] st);
    logic [31:0] r;
    wb(1'b1, `NPPF_REG_PROG, {16'h0, p, 6'h0, u}, 32'h0, r);
    wb(1'b1, `NPPF_REG_CTRL, 32'h2, 32'h0, r);
    do wb(1'b0, `NPPF_REG_STATUS, 32'h0, 32'h0, r); while (r[0] !== 1'b0);
    do wb(1'b0, `NPPF_REG_READY, 32'h0, 32'h0, r); while (r[3:0] !== 4'hf);
    wb(1'b0, `NPPF_REG_STATUS, st, 32'h18, r);
  endtask
  // Own check over the first copy
  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    c = `NPPF_CRC_INIT;
    for (int i = 0; i < 510; i++) begin
      for (int b = 7; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ pg[i][b]) ? `NPPF_CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction
  // Bus read results against the oldest note
  always @(posedge i_mclk) begin
    if (ack === 1'b1 && !we && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[63:32] != 32'h0) cmp_word(e[31:0] & e[63:32], rdat & e[63:32]);
    end
  end
  // Link bytes: first copy stored, later copies compared
  always @(posedge i_mclk) begin
    if (link.rd_valid === 1'b1 && adr_q.size() > 0) begin
      la = adr_q.pop_front();
      if (la[10:9] == 2'd0) pg[la[8:0]] = link.rd_data;
      else if (la[10:9] < 2'd3) cmp_byte(pg[la[8:0]], link.rd_data);
    end
    if (link.rd_req === 1'b1) adr_q.push_back(link.rd_addr);
  end
  // Second pair link bytes: later copies against the first
  always @(posedge i_mclk) begin
    if (link_b.rd_valid === 1'b1 && adr_qb.size() > 0) begin
      lb = adr_qb.pop_front();
      if (lb[10:9] == 2'd0) pgb[lb[8:0]] = link_b.rd_data;
      else cmp_byte(pgb[lb[8:0]], link_b.rd_data);
    end
    if (link_b.rd_req === 1'b1) adr_qb.push_back(link_b.rd_addr);
  end
  // Cuts a hang short
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [1:0]  u;
    void'($urandom(32'h4ea766b2));
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    wb(1'b1, `NPPF_REG_CTRL, 32'h1, 32'h0, r);
    wb(1'b0, `NPPF_REG_STATUS, 32'h0, 32'h3, r);
    do wb(1'b0, `NPPF_REG_READY, 32'h0, 32'h0, r); while (r[8] !== 1'b1);
    wb(1'b0, `NPPF_REG_READY, 32'h10f, 32'h1ff, r);
    wb(1'b1, `NPPF_REG_CTRL, 32'h1, 32'h0, r);
    repeat (2) @(posedge i_mclk);
    do wb(1'b0, `NPPF_REG_STATUS, 32'h0, 32'h0, r); while (r[0] !== 1'b0);
    wb(1'b0, `NPPF_REG_STATUS, 32'h2, 32'h17e, r);
    wb(1'b0, `NPPF_REG_FEAT, 32'h118, 32'hffffffff, r);
    wb(1'b0, `NPPF_REG_REV, 32'h4, 32'hffffffff, r);
    for (int k = 0; k < 21; k++) cmp_byte(TAB[k][7:0], pg[TAB[k][16:8]]);
    for (int o = 243; o < 420; o++) cmp_byte(8'h00, pg[o]);
    cmp_word({16'h0, crc_of()}, {16'h0, pg[511], pg[510]});
    cmp_word({16'h0, crc_of()}, {16'h0, page_crc});
    wb(1'b1, 8'h24, $urandom, 32'h0, r);
    wb(1'b0, 8'h24, 32'h0, 32'hffffffff, r);
    u = 2'($urandom_range(3));
    prog(u, 8'h00, 32'h0);
    prog(u + 2'd1, 8'h00, 32'h0);
    cmp_byte({4'h0, (4'h1 << u) | (4'h1 << (u + 2'd1))}, {4'h0, link.pgreg_full});
    prog(u, 8'h02, 32'h18);
    do wb(1'b0, `NPPF_REG_STATUS, 32'h0, 32'h0, r); while (rdat_b[0] !== 1'b0);
    cmp_word(32'h44, rdat_b & 32'h167);
    give_verdict();
  end
endmodule
`default_nettype wire
